// file: rtl/vdac_ctrl.sv
// register file and code generation for the voltage output converter
`timescale 1ns/1ps
`default_nettype none

module vdac_ctrl #(
    parameter int CODE_W = 12,
    parameter int BYTE_W = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    output vdac_pkg::vdac_ana_s ana_o
);

    ////////////////////////////////////////////////////////////////////
    // elaboration guard: the code field and byte lanes are fixed by the
    // register map, so any other width would need a new data path
    generate
        if (CODE_W != vdac_pkg::CODE_W) begin : g_bad_code_w
            $error("code width must stay at the converter width");
        end
        if (BYTE_W != 8) begin : g_bad_byte_w
            $error("register lanes are one byte wide");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] ctrl_r;
    logic [7:0] low_r;
    logic [7:0] high_r;
    logic [11:0] code_r;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;

    // address decode; one write strobe per register
    assign wr_low = sfr_wr_i && (sfr_addr_i == vdac_pkg::ADDR_LOW);
    assign wr_high = sfr_wr_i && (sfr_addr_i == vdac_pkg::ADDR_HIGH);
    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == vdac_pkg::ADDR_CTRL);

    // control register; reserved bits never stored
    // reserved bits dropped
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= vdac_pkg::RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_r <= sfr_wdata_i & vdac_pkg::CTRL_MASK;
        end
    end

    // data bytes; clear bit low holds them at zero, overriding writes
    // clear holds zero
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            low_r <= vdac_pkg::RST_DATA;
            high_r <= vdac_pkg::RST_DATA;
        end else if (!ctrl_r[vdac_pkg::BIT_CLR_N]) begin
            low_r <= vdac_pkg::RST_DATA;
            high_r <= vdac_pkg::RST_DATA;
        end else begin
            if (wr_low) begin
                low_r <= sfr_wdata_i;
            end
            if (wr_high) begin
                high_r <= sfr_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // converter code: latched on low byte write so a lone high write waits
    // update on low write
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            code_r <= '0;
        end else if (!ctrl_r[vdac_pkg::BIT_CLR_N]) begin
            code_r <= '0;
        end else if (wr_low) begin
            if (ctrl_r[vdac_pkg::BIT_BYTE]) begin
                code_r <= {sfr_wdata_i, 4'h0};
            end else begin
                code_r <= {high_r[3:0], sfr_wdata_i};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog controls, registered
    // pin select
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ana_o <= '0;
        end else begin
            ana_o.code <= code_r;
            ana_o.pin_alt <= ctrl_r[vdac_pkg::BIT_PIN];
            ana_o.range_avdd <= ctrl_r[vdac_pkg::BIT_RANGE];
            ana_o.powered <= ctrl_r[vdac_pkg::BIT_EN];
            ana_o.drive_en <= ctrl_r[vdac_pkg::BIT_EN];
        end
    end

    // read mux; a read has no side effect, so a stray strobe is harmless
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = sfr_rdata_o;
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                vdac_pkg::ADDR_LOW: rdata_nxt = low_r;
                vdac_pkg::ADDR_HIGH: rdata_nxt = high_r;
                vdac_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                default: rdata_nxt = 8'h00; // unmapped addresses read zero
            endcase
        end
    end

    // read data registered and held until the next read
    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sfr_rdata_o <= vdac_pkg::RST_DATA;
        end else begin
            sfr_rdata_o <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // check helper: cycles since the enable bit was seen low; saturates so
    // it never wraps back into the window right after a power-down
    logic [1:0] off_cnt_r;

    always_ff @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            off_cnt_r <= 2'h0;
        end else if (ctrl_r[vdac_pkg::BIT_EN]) begin
            off_cnt_r <= 2'h0;
        end else if (off_cnt_r != 2'h3) begin
            off_cnt_r <= off_cnt_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_r);

    low_update_a: assert property (
        (wr_low && ctrl_r[1] && !ctrl_r[3]) |-> ##2 ana_o.code == $past(
            {high_r[3:0], sfr_wdata_i}, 2))
        else $error("code not updated on low write");
    byte_mode_a: assert property (
        (wr_low && ctrl_r[1] && ctrl_r[3]) |=> code_r == {$past(sfr_wdata_i), 4'h0})
        else $error("byte mode code wrong");
    high_hold_a: assert property (
        (wr_high && !wr_low && ctrl_r[1]) |=> $stable(code_r))
        else $error("high write changed code");
    clear_hold_a: assert property (
        !ctrl_r[1] |=> (low_r == 8'h00 && high_r == 8'h00 && code_r == 12'h000))
        else $error("clear did not zero data");
    ctrl_reserved_a: assert property (
        ctrl_r[7:5] == 3'b000)
        else $error("reserved control bits set");
    pin_route_a: assert property (
        ##1 ana_o.pin_alt == $past(ctrl_r[4]))
        else $error("pin select mismatch");
    range_sel_a: assert property (
        ##1 ana_o.range_avdd == $past(ctrl_r[2]))
        else $error("range select mismatch");
    power_en_a: assert property (
        ##1 (ana_o.powered == $past(ctrl_r[0]) && ana_o.drive_en == ana_o.powered))
        else $error("enable mismatch");
    high_store_a: assert property (
        (wr_high && ctrl_r[1]) |=> high_r == $past(sfr_wdata_i))
        else $error("high byte not stored");

    ////////////////////////////////////////////////////////////////////
    // register path checks

    // low byte lands unchanged while data is writable
    low_store_a: assert property (
        (wr_low && ctrl_r[1]) |=> low_r == $past(sfr_wdata_i))
        else $error("low byte not stored");

    // upper code nibble comes from the stored high byte
    high_code_a: assert property (
        (wr_low && ctrl_r[1] && !ctrl_r[3]) |=> code_r[11:8] == $past(high_r[3:0]))
        else $error("upper code nibble wrong");

    // analog code is the latched code one edge later
    code_feed_a: assert property (
        ##1 ana_o.code == $past(code_r))
        else $error("analog code lags wrongly");

    // while clear is off, the latched code never moves without a low write
    code_hold_a: assert property (
        (!wr_low && ctrl_r[1]) |=> $stable(code_r))
        else $error("code moved without low write");

    // byte mode forces the bottom nibble to zero
    byte_low_zero_a: assert property (
        (wr_low && ctrl_r[1] && ctrl_r[3]) |-> ##2 ana_o.code[3:0] == 4'h0)
        else $error("byte mode low nibble not zero");

    // a low write during clear is swallowed
    clear_wins_a: assert property (
        (wr_low && !ctrl_r[1]) |=> low_r == 8'h00)
        else $error("low write escaped clear");

    // control write keeps only the defined bits
    ctrl_store_a: assert property (
        wr_ctrl |=> ctrl_r == ($past(sfr_wdata_i) & vdac_pkg::CTRL_MASK))
        else $error("control not stored");

    // writes to unmapped addresses leave control alone
    unmapped_wr_a: assert property (
        (sfr_wr_i && !wr_low && !wr_high && !wr_ctrl) |=> $stable(ctrl_r))
        else $error("unmapped write changed control");

    // low byte read returns the stored byte
    rd_low_a: assert property (
        (sfr_rd_i && sfr_addr_i == vdac_pkg::ADDR_LOW) |=> sfr_rdata_o == $past(low_r))
        else $error("low byte read wrong");

    // high byte read returns the stored byte
    rd_high_a: assert property (
        (sfr_rd_i && sfr_addr_i == vdac_pkg::ADDR_HIGH) |=> sfr_rdata_o == $past(high_r))
        else $error("high byte read wrong");

    // control read shows reserved bits as zero
    rd_ctrl_a: assert property (
        (sfr_rd_i && sfr_addr_i == vdac_pkg::ADDR_CTRL) |=> sfr_rdata_o == $past(ctrl_r))
        else $error("control read wrong");

    // unmapped reads return zero
    rd_other_a: assert property (
        (sfr_rd_i && sfr_addr_i != vdac_pkg::ADDR_LOW && sfr_addr_i != vdac_pkg::ADDR_HIGH
            && sfr_addr_i != vdac_pkg::ADDR_CTRL) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // read data holds between reads
    rd_hold_a: assert property (
        !sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");

    // once disabled the output stays undriven
    off_quiet_a: assert property (
        off_cnt_r != 2'h0 |-> !ana_o.drive_en)
        else $error("output driven while disabled");

    // never drive the pin from an unpowered buffer
    drive_follow_a: assert property (
        ana_o.drive_en |-> ana_o.powered)
        else $error("drive without power");

    low_write_c: cover property (wr_low && ctrl_r[1] && !ctrl_r[3]);
    byte_write_c: cover property (wr_low && ctrl_r[1] && ctrl_r[3]);
    enable_c: cover property ($rose(ana_o.drive_en));
    clear_c: cover property ($fell(ctrl_r[1]));
    read_c: cover property (sfr_rd_i && sfr_addr_i == vdac_pkg::ADDR_CTRL);

endmodule

`default_nettype wire

// file: rtl/vdac_pkg.sv
// shared constants and types for the voltage output converter control
package vdac_pkg;
    localparam logic [7:0] ADDR_LOW = 8'hFB;
    localparam logic [7:0] ADDR_HIGH = 8'hFC;
    // control register address not fixed here; neutral choice
    localparam logic [7:0] ADDR_CTRL = 8'hFD;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam int BIT_PIN = 4;
    localparam int BIT_BYTE = 3;
    localparam int BIT_RANGE = 2;
    localparam int BIT_CLR_N = 1;
    localparam int BIT_EN = 0;
    localparam logic [7:0] CTRL_MASK = 8'h1F;
    localparam int CODE_W = 12;

    // analog-side controls bundled together
    typedef struct packed {
        logic [11:0] code;
        logic pin_alt;
        logic range_avdd;
        logic powered;
        logic drive_en;
    } vdac_ana_s;
endpackage

// file: testbench/test_vdac_ctrl.sv
// self-checking bench for the converter control registers
`timescale 1ns/1ps
`default_nettype none

module test_vdac_ctrl;
    logic clk_i = 1'b0;
    logic nrst_i;
    logic [7:0] sfr_addr_i;
    logic [7:0] sfr_wdata_i;
    logic sfr_wr_i;
    logic sfr_rd_i;
    logic [7:0] sfr_rdata_o;
    vdac_pkg::vdac_ana_s ana_o;
    int n_mismatch = 0;
    int compares = 0;

    vdac_ctrl u_vdac_ctrl (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sfr_addr_i(sfr_addr_i),
        .sfr_wdata_i(sfr_wdata_i),
        .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i),
        .sfr_rdata_o(sfr_rdata_o),
        .ana_o(ana_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // 20 MHz core clock
    always #25 clk_i = ~clk_i;

    // verdict in one place, also reached from the watchdog
    task automatic wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t rdata %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_ana(input vdac_pkg::vdac_ana_s exp);
        compares++;
        if (ana_o !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t analog %h exp %h", $time, ana_o, exp);
        end
    endtask

    // strobe held until the taking edge, dropped on that same edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_wr_i <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_rd_i <= 1'b1;
        @(posedge clk_i);
        sfr_rd_i <= 1'b0;
        @(negedge clk_i);
        cmp8(sfr_rdata_o, e);
    endtask

    // two edges of margin over the two-stage code path
    task automatic settle();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        nrst_i = 1'b0;
        sfr_addr_i = 8'h00;
        sfr_wdata_i = 8'h00;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        cmp_ana(16'h0000); // off and undriven
        rd(vdac_pkg::ADDR_LOW, vdac_pkg::RST_DATA); // low reset
        rd(vdac_pkg::ADDR_HIGH, vdac_pkg::RST_DATA); // high reset
        rd(vdac_pkg::ADDR_CTRL, vdac_pkg::RST_CTRL); // control reset
        wr(vdac_pkg::ADDR_HIGH, 8'h0A); // write while clear
        rd(vdac_pkg::ADDR_HIGH, 8'h00); // held clear
        wr(vdac_pkg::ADDR_CTRL, 8'hE3); // reserved set
        rd(vdac_pkg::ADDR_CTRL, 8'h03); // reserved dropped
        settle();
        cmp_ana(16'h0003); // powered up
        wr(vdac_pkg::ADDR_HIGH, 8'h1A); // high first
        settle();
        cmp_ana(16'h0003); // high alone no change
        rd(vdac_pkg::ADDR_HIGH, 8'h1A); // high readback
        wr(vdac_pkg::ADDR_LOW, 8'hBC); // low last
        settle();
        cmp_ana({12'hABC, 4'h3}); // low write updates
        wr(vdac_pkg::ADDR_CTRL, 8'h13); // alternate pin
        wr(vdac_pkg::ADDR_LOW, 8'h5D);
        settle();
        cmp_ana({12'hA5D, 4'hB}); // alternate pin
        wr(vdac_pkg::ADDR_CTRL, 8'h07); // supply span
        settle();
        cmp_ana({12'hA5D, 4'h7}); // supply span
        wr(vdac_pkg::ADDR_CTRL, 8'h0B); // byte mode
        wr(vdac_pkg::ADDR_LOW, 8'h5D);
        settle();
        cmp_ana({12'h5D0, 4'h3}); // byte mode
        wr(vdac_pkg::ADDR_CTRL, 8'h01); // clear
        rd(vdac_pkg::ADDR_LOW, 8'h00); // clear zeros data
        settle();
        cmp_ana(16'h0003); // code cleared
        wr(vdac_pkg::ADDR_CTRL, 8'h00); // power down
        settle();
        cmp_ana(16'h0000); // powered down
        wr(8'h00, 8'h55); // unmapped write
        rd(8'h00, 8'h00); // unmapped read
        wrap_up();
    end

    // hang guard, far beyond the roughly 75 cycles the sequence needs
    initial begin
        repeat (2000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule

`default_nettype wire
